// ==== hdl/adpirq_regs.sv ====
// Feature enable, brownout threshold and interrupt mask register bank.
// Function
// - Feature bit 7 enables distortion limiter.
// - Feature bit 6 enables battery protection.
// - Feature bit 5 enables thermal foldback.
// - Feature bit 4 enables range compression.
// - Feature bit 3 enables signal generator one.
// - Feature bit 2 enables signal generator two.
// - Feature bit 1 selects battery or analog samples.
// - Feature bit 0 enables brownout supervision.
// - Eight-bit threshold, reset 0xbf, drives shutdown compare.
// - Software converts threshold code to volts.
// - Clock-mask bit 7 masks clock error.
// - Clock-mask bit 6 masks lock interrupt.
// - Output-mask bit 5 masks short circuit.
// - Output-mask bit 4 masks virtual-ground fault.
// - Output-mask bit 3 masks headset insertion.
// - Output-mask bit 2 masks headset removal.
// - Output-mask bit 1 masks hook button.
// - Aux-mask bit 7 masks upper threshold fault.
// - Aux-mask bit 6 masks lower threshold fault.
// - Clock error and lock latch; both clear when read.
`timescale 1ns/10ps
`include "adpirq_defs.svh"
module adpirq_regs (
    input  wire logic                    clk_sys_i,       // Register clock, 100 MHz.
    input  wire logic                    rst_n_i,         // Synchronous reset, active low.
    input  wire adpirq_pkg::adpirq_req_t req_i,           // Control-port read/write request.
    output logic [7:0]                   rdata_o,         // Read data, valid cycle after rd.
    input  wire adpirq_pkg::adpirq_src_t event_i,         // Interrupt source levels.
    input  wire logic [7:0]              battery_sample_i, // Battery monitor sample.
    input  wire logic [7:0]              analog_sample_i,  // Analog supply monitor sample.
    output adpirq_pkg::adpirq_feat_t     feature_o,       // Registered feature enables.
    output logic [7:0]                   sample_sel_o,    // Registered selected sample.
    output logic                         shutdown_o,      // Registered brownout shutdown.
    output logic                         irq_o            // Registered shared interrupt.
);
    adpirq_pkg::adpirq_regs_t r;
    adpirq_pkg::adpirq_regs_t next_r;
    adpirq_pkg::adpirq_feat_t feat_q;
    logic [7:0]               sample_q;
    logic [7:0]               next_sample;
    adpirq_pkg::adpirq_src_t  mask_w;
    adpirq_pkg::adpirq_src_t  pend_w;

    function automatic logic hit(input adpirq_pkg::adpirq_req_t q, input logic [7:0] ofs);
        hit = (q.addr == ofs);
    endfunction

    always_comb begin
        next_r       = r;
        next_r.rdata = `ADPIRQ_READ_NONE;
        if (req_i.wr) begin
            // Reserved bits store what is written; keeping them at reset value is software's job.
            if (hit(req_i, `ADPIRQ_OFS_FEATURE)) begin
                next_r.feature = req_i.wdata;
            end
            if (hit(req_i, `ADPIRQ_OFS_BROWNOUT)) begin
                next_r.brownout_level = req_i.wdata;
            end
            if (hit(req_i, `ADPIRQ_OFS_CLK_MASK)) begin
                next_r.clk_mask = req_i.wdata;
            end
            if (hit(req_i, `ADPIRQ_OFS_OUT_MASK)) begin
                next_r.out_mask = req_i.wdata;
            end
            if (hit(req_i, `ADPIRQ_OFS_AUX_MASK)) begin
                next_r.aux_mask = req_i.wdata;
            end
        end
        if (req_i.rd) begin
            case (req_i.addr)
                `ADPIRQ_OFS_FEATURE:  next_r.rdata = r.feature;
                `ADPIRQ_OFS_BROWNOUT: next_r.rdata = r.brownout_level;
                `ADPIRQ_OFS_CLK_MASK: next_r.rdata = r.clk_mask;
                `ADPIRQ_OFS_OUT_MASK: next_r.rdata = r.out_mask;
                `ADPIRQ_OFS_AUX_MASK: next_r.rdata = r.aux_mask;
                `ADPIRQ_OFS_LATCHED:  next_r.rdata = r.latched;
                default:              next_r.rdata = `ADPIRQ_READ_NONE;
            endcase
            if (hit(req_i, `ADPIRQ_OFS_LATCHED)) begin
                next_r.latched = `ADPIRQ_RST_LATCHED;
            end
        end
        // A new event in the read cycle wins over the clear so it is never lost.
        if (event_i.clk_err) begin
            next_r.latched[`ADPIRQ_BIT_CLK_ERR] = 1'b1;
        end
        if (event_i.pll_lock) begin
            next_r.latched[`ADPIRQ_BIT_PLL_LOCK] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            r.feature        <= `ADPIRQ_RST_FEATURE;
            r.brownout_level <= `ADPIRQ_RST_BROWNOUT;
            r.clk_mask       <= `ADPIRQ_RST_CLK_MASK;
            r.out_mask       <= `ADPIRQ_RST_OUT_MASK;
            r.aux_mask       <= `ADPIRQ_RST_AUX_MASK;
            r.latched        <= `ADPIRQ_RST_LATCHED;
            r.rdata          <= `ADPIRQ_READ_NONE;
        end else begin
            r <= next_r;
        end
    end

    always_comb begin
        next_sample = r.feature[`ADPIRQ_BIT_SRC_SEL] ? analog_sample_i
                                                     : battery_sample_i;
    end

    // Outputs are re-registered so every top-level output comes from a flip-flop.
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            feat_q   <= '0;
            sample_q <= 8'h00;
        end else begin
            feat_q.distortion <= r.feature[`ADPIRQ_BIT_DISTORTION];
            feat_q.battery    <= r.feature[`ADPIRQ_BIT_BATTERY];
            feat_q.thermal    <= r.feature[`ADPIRQ_BIT_THERMAL];
            feat_q.compress   <= r.feature[`ADPIRQ_BIT_COMPRESS];
            feat_q.siggen1    <= r.feature[`ADPIRQ_BIT_SIGGEN1];
            feat_q.siggen2    <= r.feature[`ADPIRQ_BIT_SIGGEN2];
            feat_q.src_analog <= r.feature[`ADPIRQ_BIT_SRC_SEL];
            feat_q.brownout   <= r.feature[`ADPIRQ_BIT_BROWNOUT];
            sample_q          <= next_sample;
        end
    end

    always_comb begin
        mask_w.clk_err   = r.clk_mask[`ADPIRQ_BIT_CLK_ERR];
        mask_w.pll_lock  = r.clk_mask[`ADPIRQ_BIT_PLL_LOCK];
        mask_w.out_short = r.out_mask[`ADPIRQ_BIT_OUT_SHORT];
        mask_w.vgnd      = r.out_mask[`ADPIRQ_BIT_VGND];
        mask_w.hs_insert = r.out_mask[`ADPIRQ_BIT_HS_INSERT];
        mask_w.hs_remove = r.out_mask[`ADPIRQ_BIT_HS_REMOVE];
        mask_w.hs_hook   = r.out_mask[`ADPIRQ_BIT_HS_HOOK];
        mask_w.aux_up    = r.aux_mask[`ADPIRQ_BIT_AUX_UP];
        mask_w.aux_low   = r.aux_mask[`ADPIRQ_BIT_AUX_LOW];
        pend_w           = event_i;
        // Clock and lock interrupts stay asserted from their latch until read.
        pend_w.clk_err   = r.latched[`ADPIRQ_BIT_CLK_ERR];
        pend_w.pll_lock  = r.latched[`ADPIRQ_BIT_PLL_LOCK];
    end

    adpirq_irq_combine u_irq (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .pend_i    (pend_w),
        .mask_i    (mask_w),
        .irq_o     (irq_o)
    );

    adpirq_brownout u_brownout (
        .clk_sys_i  (clk_sys_i),
        .rst_n_i    (rst_n_i),
        .enable_i   (r.feature[`ADPIRQ_BIT_BROWNOUT]),
        .level_i    (r.brownout_level),
        .sample_i   (sample_q),
        .shutdown_o (shutdown_o)
    );

    assign rdata_o      = r.rdata;
    assign feature_o    = feat_q;
    assign sample_sel_o = sample_q;
endmodule

// ==== hdl/adpirq_defs.svh ====
// Register offsets, field positions and reset values for the protect and mask register bank.
`ifndef ADPIRQ_DEFS_SVH
`define ADPIRQ_DEFS_SVH

`define ADPIRQ_OFS_FEATURE     8'h2d
`define ADPIRQ_OFS_BROWNOUT    8'h2e
`define ADPIRQ_OFS_CLK_MASK    8'h2f
`define ADPIRQ_OFS_OUT_MASK    8'h32
`define ADPIRQ_OFS_AUX_MASK    8'h33
`define ADPIRQ_OFS_LATCHED     8'h34

`define ADPIRQ_RST_FEATURE     8'h00
`define ADPIRQ_RST_BROWNOUT    8'hbf
`define ADPIRQ_RST_CLK_MASK    8'hff
`define ADPIRQ_RST_OUT_MASK    8'h00
`define ADPIRQ_RST_AUX_MASK    8'h30
`define ADPIRQ_RST_LATCHED     8'h00

`define ADPIRQ_BIT_DISTORTION  7
`define ADPIRQ_BIT_BATTERY     6
`define ADPIRQ_BIT_THERMAL     5
`define ADPIRQ_BIT_COMPRESS    4
`define ADPIRQ_BIT_SIGGEN1     3
`define ADPIRQ_BIT_SIGGEN2     2
`define ADPIRQ_BIT_SRC_SEL     1
`define ADPIRQ_BIT_BROWNOUT    0

`define ADPIRQ_BIT_CLK_ERR     7
`define ADPIRQ_BIT_PLL_LOCK    6
`define ADPIRQ_BIT_OUT_SHORT   5
`define ADPIRQ_BIT_VGND        4
`define ADPIRQ_BIT_HS_INSERT   3
`define ADPIRQ_BIT_HS_REMOVE   2
`define ADPIRQ_BIT_HS_HOOK     1
`define ADPIRQ_BIT_AUX_UP      7
`define ADPIRQ_BIT_AUX_LOW     6

`define ADPIRQ_READ_NONE       8'h00

`endif

// ==== hdl/adpirq_pkg.sv ====
// Types shared by the protect and mask register bank.
package adpirq_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } adpirq_req_t;

    typedef struct packed {
        logic distortion;
        logic battery;
        logic thermal;
        logic compress;
        logic siggen1;
        logic siggen2;
        logic src_analog;
        logic brownout;
    } adpirq_feat_t;

    typedef struct packed {
        logic clk_err;
        logic pll_lock;
        logic out_short;
        logic vgnd;
        logic hs_insert;
        logic hs_remove;
        logic hs_hook;
        logic aux_up;
        logic aux_low;
    } adpirq_src_t;

    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] brownout_level;
        logic [7:0] clk_mask;
        logic [7:0] out_mask;
        logic [7:0] aux_mask;
        logic [7:0] latched;
        logic [7:0] rdata;
    } adpirq_regs_t;

    typedef enum logic [1:0] {
        ADPIRQ_BO_IDLE  = 2'b00,
        ADPIRQ_BO_WATCH = 2'b01,
        ADPIRQ_BO_SHUT  = 2'b10
    } adpirq_bo_state_t;

    typedef struct packed {
        adpirq_bo_state_t state;
        logic             shutdown;
    } adpirq_bo_t;

    typedef struct packed {
        logic irq;
    } adpirq_irq_t;

endpackage

// ==== hdl/adpirq_brownout.sv ====
// Brownout supervisor: compares supply-monitor data with the shutdown level.
`timescale 1ns/10ps
module adpirq_brownout (
    input  wire logic       clk_sys_i,     // Register clock.
    input  wire logic       rst_n_i,       // Synchronous reset, active low.
    input  wire logic       enable_i,      // Supervision on.
    input  wire logic [7:0] level_i,       // Shutdown threshold code.
    input  wire logic [7:0] sample_i,      // Selected monitor sample, upper bits.
    output logic            shutdown_o     // Registered shutdown request.
);
    adpirq_pkg::adpirq_bo_t r;
    adpirq_pkg::adpirq_bo_t next_r;

    always_comb begin
        next_r = r;
        case (r.state)
            adpirq_pkg::ADPIRQ_BO_IDLE: begin
                next_r.shutdown = 1'b0;
                if (enable_i) begin
                    next_r.state = adpirq_pkg::ADPIRQ_BO_WATCH;
                end
            end
            adpirq_pkg::ADPIRQ_BO_WATCH: begin
                // The level is compared as a raw code; software converts it to volts.
                if (!enable_i) begin
                    next_r.state = adpirq_pkg::ADPIRQ_BO_IDLE;
                end else if (sample_i < level_i) begin
                    next_r.state    = adpirq_pkg::ADPIRQ_BO_SHUT;
                    next_r.shutdown = 1'b1;
                end
            end
            adpirq_pkg::ADPIRQ_BO_SHUT: begin
                // Shutdown holds until software drops the enable, so a noisy supply cannot chatter.
                if (!enable_i) begin
                    next_r.state    = adpirq_pkg::ADPIRQ_BO_IDLE;
                    next_r.shutdown = 1'b0;
                end
            end
            default: begin
                next_r.state    = adpirq_pkg::ADPIRQ_BO_IDLE;
                next_r.shutdown = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            r <= '{state: adpirq_pkg::ADPIRQ_BO_IDLE, shutdown: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign shutdown_o = r.shutdown;
endmodule

// ==== hdl/adpirq_irq_combine.sv ====
// Gathers the masked interrupt sources onto one registered interrupt line.
`timescale 1ns/10ps
module adpirq_irq_combine (
    input  wire logic                   clk_sys_i,   // Register clock.
    input  wire logic                   rst_n_i,     // Synchronous reset, active low.
    input  wire adpirq_pkg::adpirq_src_t pend_i,     // Raw source levels or latches.
    input  wire adpirq_pkg::adpirq_src_t mask_i,     // One masks a source.
    output logic                        irq_o        // Shared interrupt, active high.
);
    adpirq_pkg::adpirq_irq_t r;
    adpirq_pkg::adpirq_irq_t next_r;

    always_comb begin
        next_r.irq = |(pend_i & ~mask_i);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            r <= '{irq: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign irq_o = r.irq;
endmodule

// ==== test/adpirq_regs_assertions.sv ====
// Concurrent checks on the ports of the protect and mask register bank.
`timescale 1ns/10ps
`include "adpirq_defs.svh"
module adpirq_regs_assertions (
    input wire logic                     clk_sys_i,        // Register clock.
    input wire logic                     rst_n_i,          // Synchronous reset.
    input wire adpirq_pkg::adpirq_req_t  req_i,            // Register request.
    input wire logic [7:0]               rdata_o,          // Read data.
    input wire adpirq_pkg::adpirq_src_t  event_i,          // Interrupt sources.
    input wire logic [7:0]               battery_sample_i, // Battery sample.
    input wire logic [7:0]               analog_sample_i,  // Analog sample.
    input wire adpirq_pkg::adpirq_feat_t feature_o,        // Feature enables.
    input wire logic [7:0]               sample_sel_o,     // Selected sample.
    input wire logic                     shutdown_o,       // Brownout shutdown.
    input wire logic                     irq_o             // Shared interrupt.
);
    // Shadow copies of the writable registers, kept from the write requests.
    logic [7:0] sh_f, sh_b, sh_c, sh_o, sh_a, sh_r;
    logic [8:0] mvec;
    assign mvec = {sh_c[7:6], sh_o[5:1], sh_a[7:6]};
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sh_f <= `ADPIRQ_RST_FEATURE;
            sh_b <= `ADPIRQ_RST_BROWNOUT;
            sh_c <= `ADPIRQ_RST_CLK_MASK;
            sh_o <= `ADPIRQ_RST_OUT_MASK;
            sh_a <= `ADPIRQ_RST_AUX_MASK;
        end else if (req_i.wr) begin
            case (req_i.addr)
                `ADPIRQ_OFS_FEATURE:  sh_f <= req_i.wdata;
                `ADPIRQ_OFS_BROWNOUT: sh_b <= req_i.wdata;
                `ADPIRQ_OFS_CLK_MASK: sh_c <= req_i.wdata;
                `ADPIRQ_OFS_OUT_MASK: sh_o <= req_i.wdata;
                `ADPIRQ_OFS_AUX_MASK: sh_a <= req_i.wdata;
                default: ;
            endcase
        end
    end
    always_comb begin
        case (req_i.addr)
            `ADPIRQ_OFS_FEATURE:  sh_r = sh_f;
            `ADPIRQ_OFS_BROWNOUT: sh_r = sh_b;
            `ADPIRQ_OFS_CLK_MASK: sh_r = sh_c;
            `ADPIRQ_OFS_OUT_MASK: sh_r = sh_o;
            `ADPIRQ_OFS_AUX_MASK: sh_r = sh_a;
            default:              sh_r = 8'h00;
        endcase
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_low;
        sh_f[0] && sample_sel_o < sh_b;
    endsequence
    a_read_back: assert property (req_i.rd && req_i.addr != `ADPIRQ_OFS_LATCHED
        |=> rdata_o == $past(sh_r)) else $error("Read data differs from register.");
    a_read_idle: assert property (!req_i.rd |=> rdata_o == 8'h00)
        else $error("Read data not zero without a read.");
    a_feature_out: assert property ($past(rst_n_i) |-> feature_o == $past(sh_f))
        else $error("Feature enables differ from register.");
    a_sample_pick: assert property ($past(rst_n_i) && $past(sh_f[1]) == sh_f[1]
        && feature_o.src_analog == sh_f[1] |-> sample_sel_o ==
        (sh_f[1] ? $past(analog_sample_i) : $past(battery_sample_i)))
        else $error("Wrong supply sample selected.");
    a_irq_combine: assert property ($past(rst_n_i) && $past(sh_c[7:6]) == 2'b11
        |-> irq_o == $past(|(event_i[6:0] & ~mvec[6:0])))
        else $error("Shared interrupt disagrees with masked sources.");
    a_clk_unmasked: assert property (!sh_c[7] && event_i.clk_err
        |-> ##[1:3] irq_o) else $error("Unmasked clock error gave no interrupt.");
    a_shut_enabled: assert property (shutdown_o |-> sh_f[0] || $past(sh_f[0])
        || $past(sh_f[0], 2) || $past(sh_f[0], 3))
        else $error("Shutdown while supervision off.");
    a_shut_cause: assert property ($rose(shutdown_o) |-> $past(sh_f[0])
        && $past(sample_sel_o) < $past(sh_b)) else $error("Shutdown without low sample.");
    a_shut_rise: assert property (s_low [*4] |-> ##[0:2] shutdown_o)
        else $error("Low sample gave no shutdown.");
endmodule

// ==== test/test_adpirq_regs.sv ====
// Self-checking testbench for the protect and mask register bank.
`timescale 1ns/10ps
module test_adpirq_regs;
    logic                     clk_sys_i, rst_n_i, shut, irq;
    adpirq_pkg::adpirq_req_t  req;
    adpirq_pkg::adpirq_src_t  ev;
    adpirq_pkg::adpirq_feat_t feat;
    logic [7:0]               bat, ana, rdata, ssel;
    int                       errors, checks_done;
    // Offsets: feature, brownout, clock mask, output mask, aux mask, latch.
    logic [7:0] ofs [6] = '{8'h2d, 8'h2e, 8'h2f, 8'h32, 8'h33, 8'h34};
    logic [7:0] rst [6] = '{8'h00, 8'hbf, 8'hff, 8'h00, 8'h30, 8'h00};
    // Defined field bits; reserved bits are only ever written with their reset value.
    logic [7:0] fld [5] = '{8'hff, 8'hff, 8'hc0, 8'h3e, 8'hc0};
    adpirq_regs dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
        .event_i(ev), .battery_sample_i(bat), .analog_sample_i(ana), .feature_o(feat),
        .sample_sel_o(ssel), .shutdown_o(shut), .irq_o(irq));
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    // Each access takes two cycles so the request never changes twice in one step.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        req = '{w, ~w, a, d};
        cyc(1);
        req = '0;
        if (!w) chk(9'(rdata), 9'(d));
        cyc(1);
    endtask
    task automatic t_regs;
        for (int i = 0; i < 6; i++) acc(1'b0, ofs[i], rst[i]);
        acc(1'b0, 8'h30, 8'h00);
        for (int i = 0; i < 5; i++) begin
            acc(1'b1, ofs[i], rst[i] ^ fld[i]);
            acc(1'b0, ofs[i], rst[i] ^ fld[i]);
            acc(1'b1, ofs[i], rst[i]);
        end
        acc(1'b1, ofs[5], 8'hc0);
        acc(1'b0, ofs[5], 8'h00);
    endtask
    task automatic t_feature;
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, ofs[0], 8'h01 << i);
            chk(9'(feat), 9'(8'h01 << i));
        end
        bat = 8'h3c;
        ana = 8'hc3;
        acc(1'b1, ofs[0], 8'h02);
        cyc(2);
        chk(9'(ssel), 9'(8'hc3));
        acc(1'b1, ofs[0], 8'h00);
        cyc(2);
        chk(9'(ssel), 9'(8'h3c));
    endtask
    task automatic t_brownout;
        acc(1'b1, ofs[1], 8'h40);
        bat = 8'h40;
        acc(1'b1, ofs[0], 8'h01);
        cyc(4);
        chk(9'(shut), 9'h0);
        bat = 8'h3f;
        cyc(4);
        chk(9'(shut), 9'h1);
        bat = 8'h41;
        acc(1'b1, ofs[0], 8'h00);
        cyc(3);
        chk(9'(shut), 9'h0);
        acc(1'b1, ofs[1], rst[1]);
    endtask
    task automatic t_irq;
        for (int i = 0; i < 7; i++) begin
            ev = '0;
            ev[i] = 1'b1;
            cyc(2);
            chk(9'(irq), 9'h1);
            acc(1'b1, ofs[i < 2 ? 4 : 3], i < 2 ? 8'h30 | (8'h40 << i) : 8'h01 << (i - 1));
            chk(9'(irq), 9'h0);
            ev[(i + 1) % 7] = 1'b1;
            cyc(2);
            chk(9'(irq), 9'h1);
            ev = '0;
            acc(1'b1, ofs[i < 2 ? 4 : 3], rst[i < 2 ? 4 : 3]);
        end
    endtask
    task automatic t_latch(input int b, input logic [7:0] m, input logic e);
        acc(1'b1, ofs[2], m);
        ev[b] = 1'b1;
        cyc(1);
        ev = '0;
        cyc(2);
        chk(9'(irq), 9'(e));
        acc(1'b0, ofs[5], 8'h01 << (b - 1));
        acc(1'b0, ofs[5], 8'h00);
        chk(9'(irq), 9'h0);
        acc(1'b1, ofs[2], rst[2]);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        errors++;
        results();
    end
    initial begin
        {rst_n_i, req, ev, bat, ana} = '0;
        cyc(20);
        rst_n_i = 1'b1;
        chk({feat, irq}, 9'h0);
        t_regs();
        t_feature();
        t_brownout();
        t_irq();
        t_latch(8, 8'h7f, 1'b1);
        t_latch(8, 8'hff, 1'b0);
        t_latch(7, 8'hbf, 1'b1);
        t_latch(7, 8'hff, 1'b0);
        results();
    end
endmodule
bind adpirq_regs adpirq_regs_assertions u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .req_i(req_i), .rdata_o(rdata_o), .event_i(event_i), .battery_sample_i(battery_sample_i),
    .analog_sample_i(analog_sample_i), .feature_o(feature_o), .sample_sel_o(sample_sel_o),
    .shutdown_o(shutdown_o), .irq_o(irq_o));
